// >>> qpc_pkg.sv
// Constants and types for the frame priority classifier
package qpc_pkg;
   localparam int NUM_PORTS = 16;
   localparam int PORT_W = 4;
   localparam int NUM_SPECIAL = 16;
   localparam int SPECIAL_IDX_W = 4;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TAG_MAP = 8'h04;
   localparam logic [7:0] REG_TOS_MAP = 8'h08;
   localparam logic [7:0] REG_DSCP_LO = 8'h0c;
   localparam logic [7:0] REG_DSCP_HI = 8'h10;
   localparam logic [7:0] REG_SPECIAL = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_PORT_SEL = 8'h1c;
   // Control field positions
   localparam int CTRL_METHOD_LSB = 0;
   localparam int CTRL_L4_LSB = 4;
   localparam int CTRL_DEF_CLASS = 8;
   localparam int CTRL_SPEC_CLASS = 9;
   localparam int CTRL_SPEC_DEF = 10;
   localparam int CTRL_ADV = 11;
   localparam int SEL_ALL = 8;
   localparam int SPEC_EN = 16;
   localparam int SPEC_IDX_LSB = 20;
   // IP header field positions within the TOS byte
   localparam int TOS_PREC_LSB = 5;
   localparam int DSCP_LSB = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   typedef enum logic [2:0] {QPC_M_NONE, QPC_M_TAG, QPC_M_TOS, QPC_M_L4, QPC_M_DSCP} qpc_method_t;
   typedef enum logic [2:0] {QPC_L4_OFF, QPC_L4_DOWN_WEB, QPC_L4_VOIP, QPC_L4_STORAGE, QPC_L4_WEB,
      QPC_L4_STREAM, QPC_L4_DB} qpc_l4_t;
   localparam logic [15:0] WEB_PORTS [10] = '{16'h0050, 16'h0118, 16'h01bb, 16'h0019, 16'h006e,
      16'h0014, 16'h0015, 16'h0045, 16'h0077, 16'h07d9};
   localparam logic [15:0] VOIP_PORTS [3] = '{16'h06b6, 16'h06b7, 16'h06b8};
   localparam logic [15:0] STOR_PORTS [3] = '{16'h0c99, 16'h0cbc, 16'h0d5c};
   localparam logic [15:0] STREAM_PORTS [6] = '{16'h0ba3, 16'h06db, 16'h1b9e, 16'h1b9f, 16'h022a,
      16'h1f40};
   localparam logic [15:0] DB_PORTS [10] = '{16'h0042, 16'h0623, 16'h0627, 16'h020b, 16'h0076,
      16'h009c, 16'h0cea, 16'h04d0, 16'h0599, 16'h059a};
endpackage

// >>> qpc_classifier.sv
// Per-port frame priority classifier with Avalon-MM configuration
//
// Overview of operation
// [R1] Tag mode: 3-bit tag priority selects a configured high/low class.
// [R2] Mappings held per port; one write can load every port.
// [R3] TOS mode: TOS bits 5-7 index an eight-entry class map.
// [R4] Low class marks frames as discard-first under congestion.
// [R5] Layer-4 setting is exactly one of off or six profiles.
// [R6] Down-web profile: web/mail/file/news ports low, all others high.
// [R7] Voice profile: ports 1718-1720 high.
// [R8] Storage profile: ports 3225, 3260, 3420 high.
// [R9] Streaming profile: its six ports high.
// [R10] Database profile: its ten ports high.
// [R11] Web profile: the ten web/mail/file/news ports high.
// [R12] Advanced mode: programmable special port list with one match class.
// [R13] Unmatched ports in advanced mode with the layer-4 profile off take a separate default class.
// [R14] Code-point mode: 6-bit code indexes 64-entry class table.
// [R15] Unmatched frames take a default class, high after reset.
// [R16] Exactly one priority bit per frame from the selected method.
// [R17] Frames lacking the needed header field take the default class.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module qpc_classifier
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic frm_valid,
   input wire logic [3:0] frm_port,
   input wire logic frm_tagged,
   input wire logic [2:0] frm_tag_pri,
   input wire logic frm_is_ip,
   input wire logic [7:0] frm_tos,
   input wire logic frm_has_l4,
   input wire logic [15:0] frm_src_l4,
   input wire logic [15:0] frm_dst_l4,
   output logic cls_valid,
   output logic cls_high,
   output logic [3:0] cls_port
);

   // ------------------------------------------------------------
   // Configuration state
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [3:0] port_sel_q;
   logic sel_all_q;
   logic [7:0] tag_map_q [qpc_pkg::NUM_PORTS];
   logic [7:0] tos_map_q [qpc_pkg::NUM_PORTS];
   logic [31:0] dscp_lo_q [qpc_pkg::NUM_PORTS];
   logic [31:0] dscp_hi_q [qpc_pkg::NUM_PORTS];
   logic [15:0] spec_port_q [qpc_pkg::NUM_SPECIAL];
   logic [qpc_pkg::NUM_SPECIAL-1:0] spec_en_q;
   logic [31:0] frame_cnt_q;
   logic ack_q;
   logic wr_go;
   logic rd_go;
   logic [31:0] wdata;
   logic [31:0] rdata_d;
   qpc_pkg::qpc_method_t method;
   qpc_pkg::qpc_l4_t l4_sel;
   logic [2:0] l4_field;

   assign method = qpc_pkg::qpc_method_t'(ctrl_q[qpc_pkg::CTRL_METHOD_LSB +: 3]);
   assign l4_field = ctrl_q[qpc_pkg::CTRL_L4_LSB +: 3];
   // Single profile field; illegal codes behave as off
   assign l4_sel = (l4_field > 3'(qpc_pkg::QPC_L4_DB)) ? qpc_pkg::QPC_L4_OFF : qpc_pkg::qpc_l4_t'(l4_field); // [R5]

   // ------------------------------------------------------------
   // Bus handshake: one wait cycle per access
   // ------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_go = avs_write & ack_q;
   assign rd_go = avs_read & ~ack_q;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read | avs_write) & ~ack_q;
   end

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         wdata[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8] : 8'h00;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q <= qpc_pkg::CTRL_RESET; // [R15]
         port_sel_q <= 4'h0;
         sel_all_q <= 1'b0;
      end
      else if (wr_go && avs_address == qpc_pkg::REG_CTRL)
         ctrl_q <= wdata;
      else if (wr_go && avs_address == qpc_pkg::REG_PORT_SEL)
      begin
         port_sel_q <= wdata[qpc_pkg::PORT_W-1:0];
         sel_all_q <= wdata[qpc_pkg::SEL_ALL];
      end
   end

   // ------------------------------------------------------------
   // Per-port maps, all-ports broadcast write
   // ------------------------------------------------------------
   genvar gp;
   generate
      for (gp = 0; gp < qpc_pkg::NUM_PORTS; gp++)
      begin : g_port
         logic hit;
         assign hit = wr_go & (sel_all_q | (port_sel_q == 4'(gp))); // [R2]
         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
            begin
               tag_map_q[gp] <= 8'hff;
               tos_map_q[gp] <= 8'hff;
               dscp_lo_q[gp] <= 32'hffff_ffff;
               dscp_hi_q[gp] <= 32'hffff_ffff;
            end
            else if (hit)
            begin
               if (avs_address == qpc_pkg::REG_TAG_MAP)
                  tag_map_q[gp] <= wdata[7:0];
               if (avs_address == qpc_pkg::REG_TOS_MAP)
                  tos_map_q[gp] <= wdata[7:0];
               if (avs_address == qpc_pkg::REG_DSCP_LO)
                  dscp_lo_q[gp] <= wdata;
               if (avs_address == qpc_pkg::REG_DSCP_HI)
                  dscp_hi_q[gp] <= wdata;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Special port list, loaded one entry per write
   // ------------------------------------------------------------
   genvar gs;
   generate
      for (gs = 0; gs < qpc_pkg::NUM_SPECIAL; gs++)
      begin : g_spec
         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
            begin
               spec_port_q[gs] <= 16'h0000;
               spec_en_q[gs] <= 1'b0;
            end
            else if (wr_go && avs_address == qpc_pkg::REG_SPECIAL &&
               wdata[qpc_pkg::SPEC_IDX_LSB +: qpc_pkg::SPECIAL_IDX_W] == 4'(gs))
            begin
               spec_port_q[gs] <= wdata[15:0]; // [R12]
               spec_en_q[gs] <= wdata[qpc_pkg::SPEC_EN];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Register read mux
   // ------------------------------------------------------------
   always_comb
   begin
      case (avs_address)
         qpc_pkg::REG_CTRL: rdata_d = ctrl_q;
         qpc_pkg::REG_TAG_MAP: rdata_d = {24'h000000, tag_map_q[port_sel_q]};
         qpc_pkg::REG_TOS_MAP: rdata_d = {24'h000000, tos_map_q[port_sel_q]};
         qpc_pkg::REG_DSCP_LO: rdata_d = dscp_lo_q[port_sel_q];
         qpc_pkg::REG_DSCP_HI: rdata_d = dscp_hi_q[port_sel_q];
         qpc_pkg::REG_STATUS: rdata_d = frame_cnt_q;
         qpc_pkg::REG_PORT_SEL: rdata_d = {23'h000000, sel_all_q, 4'h0, port_sel_q};
         default: rdata_d = qpc_pkg::UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         avs_readdata <= 32'h0000_0000;
      else if (rd_go)
         avs_readdata <= rdata_d;
   end

   // ------------------------------------------------------------
   // Layer-4 matching
   // ------------------------------------------------------------
   function automatic logic in_list10(input logic [15:0] p, input logic [15:0] l [10]);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 10; i++)
         r = r | (p == l[i]);
      return r;
   endfunction

   function automatic logic in_list6(input logic [15:0] p, input logic [15:0] l [6]);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 6; i++)
         r = r | (p == l[i]);
      return r;
   endfunction

   function automatic logic in_list3(input logic [15:0] p, input logic [15:0] l [3]);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 3; i++)
         r = r | (p == l[i]);
      return r;
   endfunction

   logic web_hit;
   logic voip_hit;
   logic stor_hit;
   logic stream_hit;
   logic db_hit;
   logic spec_hit;
   logic def_class;
   logic l4_class;
   logic cls_d;
   logic [2:0] tos_idx;
   logic [5:0] dscp_idx;
   logic [63:0] dscp_tab;

   assign web_hit = in_list10(frm_src_l4, qpc_pkg::WEB_PORTS) | in_list10(frm_dst_l4, qpc_pkg::WEB_PORTS);
   assign voip_hit = in_list3(frm_src_l4, qpc_pkg::VOIP_PORTS) | in_list3(frm_dst_l4, qpc_pkg::VOIP_PORTS);
   assign stor_hit = in_list3(frm_src_l4, qpc_pkg::STOR_PORTS) | in_list3(frm_dst_l4, qpc_pkg::STOR_PORTS);
   assign stream_hit = in_list6(frm_src_l4, qpc_pkg::STREAM_PORTS) |
      in_list6(frm_dst_l4, qpc_pkg::STREAM_PORTS);
   assign db_hit = in_list10(frm_src_l4, qpc_pkg::DB_PORTS) | in_list10(frm_dst_l4, qpc_pkg::DB_PORTS);

   always_comb
   begin
      spec_hit = 1'b0;
      for (int i = 0; i < qpc_pkg::NUM_SPECIAL; i++)
         spec_hit = spec_hit | (spec_en_q[i] & ((frm_src_l4 == spec_port_q[i]) | (frm_dst_l4 == spec_port_q[i])));
   end

   assign def_class = ctrl_q[qpc_pkg::CTRL_DEF_CLASS];

   always_comb
   begin
      l4_class = def_class;
      // Advanced list adds to the built-in profile and wins over it
      if (ctrl_q[qpc_pkg::CTRL_ADV] && spec_hit)
         l4_class = ctrl_q[qpc_pkg::CTRL_SPEC_CLASS]; // [R12]
      else
      begin
         case (l4_sel)
            qpc_pkg::QPC_L4_DOWN_WEB: l4_class = ~web_hit; // [R6]
            qpc_pkg::QPC_L4_VOIP: l4_class = voip_hit; // [R7]
            qpc_pkg::QPC_L4_STORAGE: l4_class = stor_hit; // [R8]
            qpc_pkg::QPC_L4_WEB: l4_class = web_hit; // [R11]
            qpc_pkg::QPC_L4_STREAM: l4_class = stream_hit; // [R9]
            qpc_pkg::QPC_L4_DB: l4_class = db_hit; // [R10]
            default: l4_class = ctrl_q[qpc_pkg::CTRL_ADV] ? ctrl_q[qpc_pkg::CTRL_SPEC_DEF] : def_class; // [R13]
         endcase
      end
   end

   // ------------------------------------------------------------
   // Method select, one class bit per frame
   // ------------------------------------------------------------
   assign tos_idx = frm_tos[qpc_pkg::TOS_PREC_LSB +: 3]; // [R3]
   assign dscp_idx = frm_tos[qpc_pkg::DSCP_LSB +: 6];
   assign dscp_tab = {dscp_hi_q[frm_port], dscp_lo_q[frm_port]};

   always_comb
   begin
      case (method)
         qpc_pkg::QPC_M_TAG: cls_d = frm_tagged ? tag_map_q[frm_port][frm_tag_pri] : def_class; // [R1] [R15]
         qpc_pkg::QPC_M_TOS: cls_d = frm_is_ip ? tos_map_q[frm_port][tos_idx] : def_class; // [R3] [R17]
         qpc_pkg::QPC_M_DSCP: cls_d = frm_is_ip ? dscp_tab[dscp_idx] : def_class; // [R14] [R17]
         qpc_pkg::QPC_M_L4: cls_d = (frm_is_ip && frm_has_l4) ? l4_class : def_class; // [R17]
         default: cls_d = def_class;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cls_valid <= 1'b0;
         cls_high <= 1'b1;
         cls_port <= 4'h0;
      end
      else
      begin
         cls_valid <= frm_valid; // [R16]
         if (frm_valid)
         begin
            cls_high <= cls_d; // [R4] [R16]
            cls_port <= frm_port;
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         frame_cnt_q <= 32'h0000_0000;
      else if (frm_valid && !cls_d)
         frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
   end

endmodule // qpc_classifier

// >>> qpc_classifier_sva.sv
// Assertion checker for the frame priority classifier
`timescale 1ns/1ps
module qpc_classifier_sva
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic frm_valid,
   input wire logic [3:0] frm_port,
   input wire logic frm_tagged,
   input wire logic frm_is_ip,
   input wire logic frm_has_l4,
   input wire logic [15:0] frm_dst_l4,
   input wire logic cls_valid,
   input wire logic cls_high,
   input wire logic [3:0] cls_port
);
   logic [31:0] ctrl_q;
   logic [2:0] m;
   logic dflt;
   logic voip;
   // -----------------------------
   // Shadow of the control word
   // -----------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         ctrl_q <= qpc_pkg::CTRL_RESET;
      else if (avs_write && !avs_waitrequest && avs_address == qpc_pkg::REG_CTRL)
         ctrl_q <= avs_writedata;
   end
   assign m = ctrl_q[2:0];
   assign dflt = (m == 3'd0) || (m == 3'd1 && !frm_tagged) || (m >= 3'd2 && m <= 3'd4 && !frm_is_ip)
      || (m == 3'd3 && !frm_has_l4);
   assign voip = m == 3'd3 && ctrl_q[6:4] == 3'd2 && !ctrl_q[11] && frm_is_ip && frm_has_l4
      && frm_dst_l4 >= 16'h06b6 && frm_dst_l4 <= 16'h06b8;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_cls_latency: assert property (frm_valid |=> cls_valid)
      else $error("classification missing one cycle after frame");
   a_no_spurious: assert property (!frm_valid |=> !cls_valid)
      else $error("classification without a frame");
   a_port_carry: assert property (frm_valid |=> cls_port == $past(frm_port))
      else $error("classified port differs from ingress port");
   a_class_hold: assert property (!frm_valid |=> $stable(cls_high) && $stable(cls_port))
      else $error("class output changed without a frame");
   a_default_class: assert property (frm_valid && dflt |=> cls_high == $past(ctrl_q[8]))
      else $error("unmatched frame did not take default class");
   a_voip_high: assert property (frm_valid && voip |=> cls_high)
      else $error("voice port frame not high");
   a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus wait longer than one cycle");
   a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("new bus request answered without wait");
endmodule // qpc_classifier_sva

bind qpc_classifier qpc_classifier_sva u_sva (.clock(clock), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest), .frm_valid(frm_valid), .frm_port(frm_port),
   .frm_tagged(frm_tagged), .frm_is_ip(frm_is_ip), .frm_has_l4(frm_has_l4), .frm_dst_l4(frm_dst_l4),
   .cls_valid(cls_valid), .cls_high(cls_high), .cls_port(cls_port));

// >>> qpc_queue_model.sv
// Queue manager model that discards low frames under congestion
`timescale 1ns/1ps
module qpc_queue_model
(
   input wire logic clock,
   input wire logic rst,
   input wire logic congested,
   input wire logic cls_valid,
   input wire logic cls_high,
   output logic [15:0] drop_count,
   output logic [15:0] fwd_count
);
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         drop_count <= 16'h0000;
         fwd_count <= 16'h0000;
      end
      else if (cls_valid && congested && !cls_high)
         drop_count <= drop_count + 16'h0001;
      else if (cls_valid)
         fwd_count <= fwd_count + 16'h0001;
   end
endmodule // qpc_queue_model

// >>> tb.sv
// Self-checking testbench for the frame priority classifier
`timescale 1ns/1ps
module tb;
   logic clock, rst, avs_read, avs_write, avs_waitrequest, frm_valid, frm_tagged, frm_is_ip, frm_has_l4;
   logic cls_valid, cls_high;
   logic [7:0] avs_address, frm_tos;
   logic [31:0] avs_writedata, avs_readdata, rs;
   logic [3:0] avs_byteenable, frm_port, cls_port;
   logic [2:0] frm_tag_pri;
   logic [15:0] frm_src_l4, frm_dst_l4, drop_count, fwd_count;
   logic [4:0] exq[$];
   int bad_count, cmp_count, nlow, nfrm;
   qpc_classifier u_dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frm_valid(frm_valid),
      .frm_port(frm_port), .frm_tagged(frm_tagged), .frm_tag_pri(frm_tag_pri), .frm_is_ip(frm_is_ip),
      .frm_tos(frm_tos), .frm_has_l4(frm_has_l4), .frm_src_l4(frm_src_l4), .frm_dst_l4(frm_dst_l4),
      .cls_valid(cls_valid), .cls_high(cls_high), .cls_port(cls_port));
   qpc_queue_model u_qm (.clock(clock), .rst(rst), .congested(1'b1), .cls_valid(cls_valid),
      .cls_high(cls_high), .drop_count(drop_count), .fwd_count(fwd_count));
   always #5 clock = ~clock;
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // -----------------------------
   // Bus master; also ends a frame burst
   // -----------------------------
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      int n;
      @(posedge clock);
      frm_valid <= 1'b0;
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= wd;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         bad_count++;
         test_done();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b1, a, 32'h0000_0000, q);
      check(q, e);
   endtask
   // Frames issued back to back until the next bus access
   // Tagged IP frames carry no layer-4 header
   task automatic frm(input logic [3:0] p, input logic t, input logic [2:0] c, input logic ip,
      input logic [7:0] tos, input logic [15:0] s, input logic [15:0] d, input logic e);
      @(posedge clock);
      frm_valid <= 1'b1;
      frm_port <= p;
      frm_tagged <= t;
      frm_tag_pri <= c;
      frm_is_ip <= ip;
      frm_has_l4 <= ip & ~t;
      frm_tos <= tos;
      frm_src_l4 <= s;
      frm_dst_l4 <= d;
      exq.push_back({p, e});
      nlow += int'(!e);
      nfrm++;
   endtask
   always @(posedge clock)
   begin
      if (cls_valid === 1'b1)
      begin
         if (exq.size() == 0)
            exq.push_back(~{cls_port, cls_high});
         check({cls_port, cls_high}, exq.pop_front());
      end
   end
   initial
   begin
      logic [7:0] k;
      logic [63:0] dm;
      logic [31:0] v;
      logic [15:0] pt;
      {clock, avs_read, avs_write, frm_valid, frm_tagged, frm_is_ip, frm_has_l4} = 7'h00;
      {avs_address, frm_tos, frm_port, frm_tag_pri, frm_src_l4, frm_dst_l4} = 55'h0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hf;
      rs = 32'hfa43;
      rst = 1'b1;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      rdchk(qpc_pkg::REG_CTRL, qpc_pkg::CTRL_RESET);
      rdchk(qpc_pkg::REG_TAG_MAP, 32'h0000_00ff);
      rdchk(8'h20, qpc_pkg::UNMAPPED_READ);
      avs_byteenable <= 4'h2;
      wr(qpc_pkg::REG_TAG_MAP, 32'h0000_a55a);
      avs_byteenable <= 4'hf;
      rdchk(qpc_pkg::REG_TAG_MAP, 32'h0000_0000);
      $display("test reset done");
      wr(qpc_pkg::REG_PORT_SEL, 32'h0000_0100);
      wr(qpc_pkg::REG_TAG_MAP, 32'h0000_00a5);
      wr(qpc_pkg::REG_PORT_SEL, 32'h0000_0003);
      wr(qpc_pkg::REG_TAG_MAP, 32'h0000_0000);
      rdchk(qpc_pkg::REG_TAG_MAP, 32'h0000_0000);
      wr(qpc_pkg::REG_CTRL, 32'h0000_0001);
      k = 8'ha5;
      for (int i = 0; i < 8; i++)
      begin
         frm(4'h5, 1'b1, i[2:0], 1'b1, 8'h00, 16'h0, 16'h0, k[i]);
         frm(4'h3, 1'b1, i[2:0], 1'b0, 8'h00, 16'h0, 16'h0, 1'b0);
      end
      frm(4'h5, 1'b0, 3'h0, 1'b1, 8'h00, 16'h0, 16'h0, 1'b0);
      $display("test tag done");
      wr(qpc_pkg::REG_PORT_SEL, 32'h0000_0100);
      wr(qpc_pkg::REG_TOS_MAP, 32'h0000_003c);
      wr(qpc_pkg::REG_CTRL, 32'h0000_0002);
      k = 8'h3c;
      for (int i = 0; i < 8; i++)
      begin
         v = rnd();
         frm(v[3:0], v[4], v[7:5], 1'b1, {i[2:0], v[12:8]}, v[31:16], v[15:0], k[i]);
      end
      frm(4'h9, 1'b1, 3'h0, 1'b0, 8'he0, 16'h0, 16'h0, 1'b0);
      dm = {rnd(), rnd()};
      wr(qpc_pkg::REG_DSCP_LO, dm[31:0]);
      wr(qpc_pkg::REG_DSCP_HI, dm[63:32]);
      wr(qpc_pkg::REG_CTRL, 32'h0000_0004);
      for (int i = 0; i < 64; i++)
      begin
         v = rnd();
         frm(v[3:0], v[4], v[7:5], 1'b1, {i[5:0], v[9:8]}, v[31:16], v[15:0], dm[i]);
      end
      $display("test tos and code point done");
      for (int p = 1; p < 7; p++)
      begin
         wr(qpc_pkg::REG_CTRL, {25'h0, p[2:0], 4'h3});
         for (int i = 0; i < 10; i++)
         begin
            case (p)
               1, 4: pt = qpc_pkg::WEB_PORTS[i];
               2: pt = qpc_pkg::VOIP_PORTS[i % 3];
               3: pt = qpc_pkg::STOR_PORTS[i % 3];
               5: pt = qpc_pkg::STREAM_PORTS[i % 6];
               default: pt = qpc_pkg::DB_PORTS[i];
            endcase
            v = rnd();
            frm(v[3:0], 1'b0, 3'h0, 1'b1, v[15:8], v[16] ? pt : 16'h9999,
               v[16] ? 16'h9999 : pt, p != 1);
         end
         frm(4'h2, 1'b0, 3'h0, 1'b1, 8'h00, 16'h9999, 16'h9999, p == 1);
         frm(4'h2, 1'b1, 3'h0, 1'b1, 8'h00, pt, pt, 1'b0);
      end
      wr(qpc_pkg::REG_CTRL, 32'h0000_0173);
      frm(4'h1, 1'b0, 3'h0, 1'b1, 8'h00, 16'h0050, 16'h0050, 1'b1);
      wr(qpc_pkg::REG_SPECIAL, 32'h0051_4321);
      wr(qpc_pkg::REG_CTRL, 32'h0000_0c03);
      frm(4'h7, 1'b0, 3'h0, 1'b1, 8'h00, 16'h0001, 16'h4321, 1'b0);
      frm(4'h7, 1'b0, 3'h0, 1'b1, 8'h00, 16'h0001, 16'h1234, 1'b1);
      $display("test layer four done");
      wr(qpc_pkg::REG_CTRL, 32'h0000_0100);
      for (int i = 0; i < 20; i++)
      begin
         v = rnd();
         frm(v[3:0], v[4], v[7:5], v[8], v[23:16], v[31:16], v[15:0], 1'b1);
      end
      wr(qpc_pkg::REG_PORT_SEL, 32'h0000_0000);
      rdchk(qpc_pkg::REG_STATUS, nlow);
      check({16'h0, drop_count}, nlow);
      check({16'h0, fwd_count}, nfrm - nlow);
      $display("test default and congestion done");
      test_done();
   end
endmodule // tb
